// >>> abu_pkg.sv
// Purpose: shared constants of the address breakpoint unit
// Assumes: registers are 32-bit APB words at four times their index
// Notes: pulse length is counted in cpu clock cycles
package abu_pkg;

   // ----------------------------------------------------------------
   // register indices and apb geometry
   // ----------------------------------------------------------------
   localparam int APB_AW = 18;
   localparam logic [15:0] IDX_CTRL = 16'hE605;
   localparam logic [15:0] IDX_ADDRH = 16'hE606;
   localparam logic [15:0] IDX_ADDRL = 16'hE607;
   localparam logic [15:0] IDX_STAT = 16'hE610;
   localparam logic [15:0] IDX_MASK = 16'hE611;

   // ----------------------------------------------------------------
   // field positions of breakpoint_control
   // ----------------------------------------------------------------
   localparam int BIT_EN = 1;
   localparam int BIT_PULSE = 2;
   localparam int BIT_BREAK = 3;

   // ----------------------------------------------------------------
   // reset values and counts
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [15:0] RST_MATCH = 16'h0000;
   localparam logic RST_STAT = 1'b0;
   localparam logic RST_MASK = 1'b0;
   localparam int PULSE_CYCLES = 8;

   // byte address of a register index
   function automatic logic [APB_AW-1:0] byte_addr(input logic [15:0] idx);
      return {idx, 2'b00};
   endfunction

endpackage

// >>> abu_top.sv
// Purpose: address breakpoint unit with apb register access
// Assumes: cpu bus strobes come from logic on pclk, one strobe per bus cycle
// Notes: breakpoint_pin is the flag flip-flop itself
//
// Behaviour
// [RL1] while enabled, a full 16-bit address equal to the match address is an event
// [RL2] both code fetches and external data accesses are compared
// [RL3] the breakpoint pin always shows the breakpoint flag
// [RL4] pulse mode: flag and pin high exactly eight cpu clock cycles per match; a clearing write cuts the pulse short and a new match restarts the count
// [RL5] latched mode: flag and pin stay high until firmware clears them
// [RL6] writing one to the flag bit clears it; writing zero leaves it
// [RL7] firmware need not clear the flag in pulse mode
// [RL8] pulse mode select chooses latched level or timed pulse
// [RL9] match address is two read/write bytes, high and low
// [RL10] compare every bus cycle, flag registers on the next edge
module abu_top #(
   parameter int PULSE_LEN = abu_pkg::PULSE_CYCLES
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [abu_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // cpu bus
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_code_fetch,
   input wire logic cpu_external_data_space_access,
   // breakpoint outputs
   output logic breakpoint_pin,
   output logic irq
);

   // ----------------------------------------------------------------
   // parameter check
   // ----------------------------------------------------------------
   if (PULSE_LEN < 1 || PULSE_LEN > 16) begin : g_bad_len
      $error("PULSE_LEN must lie in 1..16");
   end

   // loaded one below the length: the flag is still high while the count reads zero
   localparam logic [3:0] CNT_LOAD = 4'(PULSE_LEN - 1);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic breakpoint_enable;
      logic pulse_mode_select;
      logic brk;
      logic [3:0] cnt;
      logic [15:0] match_addr;
      logic status;
      logic mask;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic irq;
   } abu_state_s;

   abu_state_s state_reg;
   abu_state_s state_next;

   // strobes decoded in this cycle, shared by the next-state logic and the checks
   logic hit;
   logic wr_acc;
   logic clr_brk;
   logic pulse_sel;

   function automatic logic is_reg(input logic [abu_pkg::APB_AW-1:0] a,
                                   input logic [15:0] idx);
      return a == abu_pkg::byte_addr(idx);
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      // compare on code and external data bus cycles alike
      hit = state_reg.breakpoint_enable && (cpu_code_fetch || cpu_external_data_space_access) //RL2
         && (cpu_addr == state_reg.match_addr); //RL1
      wr_acc = psel && penable && pwrite && state_reg.ready;
      clr_brk = wr_acc && is_reg(paddr, abu_pkg::IDX_CTRL) && pwdata[abu_pkg::BIT_BREAK];

      // register writes
      if (wr_acc) begin
         if (is_reg(paddr, abu_pkg::IDX_CTRL)) begin
            state_next.breakpoint_enable = pwdata[abu_pkg::BIT_EN];
            state_next.pulse_mode_select = pwdata[abu_pkg::BIT_PULSE];
         end
         if (is_reg(paddr, abu_pkg::IDX_ADDRH)) begin
            state_next.match_addr[15:8] = pwdata[7:0]; //RL9
         end
         if (is_reg(paddr, abu_pkg::IDX_ADDRL)) begin
            state_next.match_addr[7:0] = pwdata[7:0]; //RL9
         end
         if (is_reg(paddr, abu_pkg::IDX_MASK)) begin
            state_next.mask = pwdata[0];
         end
         if (is_reg(paddr, abu_pkg::IDX_STAT) && pwdata[0]) begin
            state_next.status = 1'b0;
         end
      end
      pulse_sel = state_reg.pulse_mode_select;

      // breakpoint flag: a match wins over a clearing write
      if (pulse_sel) begin //RL8
         if (hit) begin
            state_next.brk = 1'b1; //RL4
            state_next.cnt = CNT_LOAD; //RL10
         end else if (clr_brk) begin
            state_next.brk = 1'b0; //RL6
            state_next.cnt = 4'h0;
         end else if (state_reg.cnt != 4'h0) begin
            state_next.cnt = state_reg.cnt - 4'h1;
         end else begin
            state_next.brk = 1'b0; //RL4
         end
      end else begin
         state_next.cnt = 4'h0;
         if (hit) begin
            state_next.brk = 1'b1; //RL5
         end else if (clr_brk) begin
            state_next.brk = 1'b0; //RL6
         end
      end

      // sticky event bit, set wins over clear
      if (hit) begin
         state_next.status = 1'b1;
      end
      state_next.irq = state_next.status && state_next.mask;

      // apb answer: data and ready prepared in the setup cycle
      state_next.ready = psel && !penable;
      state_next.slverr = 1'b0;
      state_next.rdata = 32'h0000_0000;
      if (psel && !penable) begin
         if (is_reg(paddr, abu_pkg::IDX_CTRL)) begin
            state_next.rdata[abu_pkg::BIT_EN] = state_reg.breakpoint_enable;
            state_next.rdata[abu_pkg::BIT_PULSE] = state_reg.pulse_mode_select;
            state_next.rdata[abu_pkg::BIT_BREAK] = state_next.brk;
         end else if (is_reg(paddr, abu_pkg::IDX_ADDRH)) begin
            state_next.rdata[7:0] = state_next.match_addr[15:8];
         end else if (is_reg(paddr, abu_pkg::IDX_ADDRL)) begin
            state_next.rdata[7:0] = state_next.match_addr[7:0];
         end else if (is_reg(paddr, abu_pkg::IDX_STAT)) begin
            state_next.rdata[0] = state_next.status;
         end else if (is_reg(paddr, abu_pkg::IDX_MASK)) begin
            state_next.rdata[0] = state_next.mask;
         end else begin
            state_next.slverr = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg.breakpoint_enable <= abu_pkg::RST_CTRL[abu_pkg::BIT_EN];
         state_reg.pulse_mode_select <= abu_pkg::RST_CTRL[abu_pkg::BIT_PULSE];
         state_reg.brk <= abu_pkg::RST_CTRL[abu_pkg::BIT_BREAK];
         state_reg.cnt <= 4'h0;
         state_reg.match_addr <= abu_pkg::RST_MATCH;
         state_reg.status <= abu_pkg::RST_STAT;
         state_reg.mask <= abu_pkg::RST_MASK;
         state_reg.rdata <= 32'h0000_0000;
         state_reg.ready <= 1'b0;
         state_reg.slverr <= 1'b0;
         state_reg.irq <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign breakpoint_pin = state_reg.brk; //RL3
   assign irq = state_reg.irq;
   assign prdata = state_reg.rdata;
   assign pready = state_reg.ready;
   assign pslverr = state_reg.slverr;

   // ----------------------------------------------------------------
   // checks on the cpu side
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   match_sets_flag_a: assert property (hit |=> breakpoint_pin) //RL1
      else $error("match did not raise the flag next edge");

   enable_gate_a: assert property ( //RL1
      !state_reg.breakpoint_enable |=> !$rose(breakpoint_pin))
      else $error("flag rose while the unit was disabled");

   flag_cause_a: assert property ($rose(breakpoint_pin) |-> $past(hit)) //RL10
      else $error("flag rose without a match");

   source_both_a: assert property ( //RL2
      (state_reg.breakpoint_enable && cpu_external_data_space_access && !cpu_code_fetch
       && cpu_addr == state_reg.match_addr) |=> breakpoint_pin)
      else $error("external data match missed");

   pin_readback_a: assert property ( //RL3
      (pready && psel && !pwrite && is_reg(paddr, abu_pkg::IDX_CTRL))
      |-> prdata[abu_pkg::BIT_BREAK] == breakpoint_pin)
      else $error("flag readback differs from pin");

   pulse_start_a: assert property ( //RL4
      (hit && pulse_sel) |=> breakpoint_pin && state_reg.cnt == CNT_LOAD)
      else $error("pulse did not start with full count");

   pulse_count_a: assert property ( //RL4
      (breakpoint_pin && pulse_sel && state_reg.cnt != 4'h0 && !hit && !clr_brk)
      |=> breakpoint_pin && state_reg.cnt == $past(state_reg.cnt) - 4'h1)
      else $error("pulse count did not step down");

   pulse_end_a: assert property ( //RL4
      (breakpoint_pin && pulse_sel && state_reg.cnt == 4'h0 && !hit)
      |=> !breakpoint_pin)
      else $error("pulse did not end after its count");

   latch_hold_a: assert property ( //RL5
      (breakpoint_pin && !pulse_sel && !clr_brk) |=> breakpoint_pin)
      else $error("latched flag dropped without clear");

   clear_flag_a: assert property ((clr_brk && !hit) |=> !breakpoint_pin) //RL6
      else $error("write one did not clear the flag");

   pulse_cut_a: assert property ( //RL6
      (clr_brk && !hit && pulse_sel) |=> state_reg.cnt == 4'h0)
      else $error("clearing write did not end the pulse");

   write_zero_a: assert property ( //RL6
      (wr_acc && is_reg(paddr, abu_pkg::IDX_CTRL) && !pwdata[abu_pkg::BIT_BREAK]
       && breakpoint_pin && !pulse_sel) |=> breakpoint_pin)
      else $error("writing zero dropped the latched flag");

   mode_select_a: assert property ( //RL8
      (!pulse_sel && breakpoint_pin && state_reg.cnt == 4'h0 && !clr_brk)
      ##1 !pulse_sel |-> breakpoint_pin)
      else $error("latched mode behaved as a pulse");

   // ----------------------------------------------------------------
   // checks on the register side
   // ----------------------------------------------------------------
   setup_ready_a: assert property ((psel && !penable) |=> pready)
      else $error("no ready in the access cycle");

   slverr_ready_a: assert property (pslverr |-> pready)
      else $error("error response without ready");

   addr_high_a: assert property ( //RL9
      (wr_acc && is_reg(paddr, abu_pkg::IDX_ADDRH))
      |=> state_reg.match_addr[15:8] == $past(pwdata[7:0]))
      else $error("high match byte not stored");

   addr_low_a: assert property ( //RL9
      (wr_acc && is_reg(paddr, abu_pkg::IDX_ADDRL))
      |=> state_reg.match_addr[7:0] == $past(pwdata[7:0]))
      else $error("low match byte not stored");

   readback_low_a: assert property ( //RL9
      (pready && psel && !pwrite && is_reg(paddr, abu_pkg::IDX_ADDRL))
      |-> prdata[7:0] == state_reg.match_addr[7:0])
      else $error("low match byte readback differs");

   unmapped_write_a: assert property (
      (wr_acc && pslverr)
      |=> $stable(state_reg.match_addr) && $stable(state_reg.mask))
      else $error("write to an unmapped address took effect");

   readback_mask_a: assert property (
      (pready && psel && !pwrite && is_reg(paddr, abu_pkg::IDX_MASK))
      |-> prdata[0] == state_reg.mask)
      else $error("mask readback differs");

   status_set_a: assert property (hit |=> state_reg.status) //RL1
      else $error("match did not set the status bit");

   status_clear_a: assert property (
      (wr_acc && is_reg(paddr, abu_pkg::IDX_STAT) && pwdata[0] && !hit)
      |=> !state_reg.status)
      else $error("write one did not clear the status bit");

   irq_event_a: assert property ((hit && state_reg.mask && !wr_acc) |=> irq)
      else $error("unmasked match did not raise the interrupt");

   irq_level_a: assert property (irq == (state_reg.status && state_reg.mask))
      else $error("interrupt differs from masked status");

endmodule

// >>> abu_probe.sv
// Purpose: debug equipment watching the breakpoint pin
// Assumes: pin is sampled on rising pclk edges
// Notes: keeps the length of the last high pulse in cycles
module abu_probe (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // observed pin
   input wire logic breakpoint_pin,
   // measurement
   output logic [7:0] high_len
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] run_cnt;
   // ----------------------------------------------------------------
   // pulse length measurement
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_cnt <= 8'h00;
         high_len <= 8'h00;
      end else if (breakpoint_pin) begin
         run_cnt <= run_cnt + 8'h01;
      end else if (run_cnt != 8'h00) begin
         high_len <= run_cnt;
         run_cnt <= 8'h00;
      end
   end
endmodule

// >>> abu_top_tb.sv
// Purpose: self-checking bench of the address breakpoint unit
// Assumes: apb answers without a fixed latency; bench waits for pready
// Notes: match address reset value is never relied on
module abu_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [17:0] paddr = 18'h00000;
   logic [31:0] pwdata = 32'h00000000;
   logic [15:0] cpu_addr = 16'h0000;
   logic cpu_code_fetch = 1'b0;
   logic cpu_external_data_space_access = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic breakpoint_pin;
   logic irq;
   logic [7:0] high_len;
   logic [31:0] rd;
   logic err;
   int failures = 0;
   int cmp_count = 0;
   always #25 pclk = ~pclk;
   abu_top #(.PULSE_LEN(abu_pkg::PULSE_CYCLES)) dut_u (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_addr(cpu_addr),
      .cpu_code_fetch(cpu_code_fetch), .cpu_external_data_space_access(cpu_external_data_space_access),
      .breakpoint_pin(breakpoint_pin), .irq(irq));
   abu_probe probe_u (.pclk(pclk), .presetn(presetn), .breakpoint_pin(breakpoint_pin),
      .high_len(high_len));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic cpu(input logic [15:0] a, input logic c, input logic x);
      @(posedge pclk);
      cpu_addr <= a;
      cpu_code_fetch <= c;
      cpu_external_data_space_access <= x;
      @(posedge pclk);
      cpu_code_fetch <= 1'b0;
      cpu_external_data_space_access <= 1'b0;
      #1;
   endtask
   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs;
      chk(breakpoint_pin, 1'b0);
      apb(1'b1, abu_pkg::IDX_ADDRH, 32'h000000AB);
      apb(1'b1, abu_pkg::IDX_ADDRL, 32'h000000CD);
      apb(1'b0, abu_pkg::IDX_ADDRH, 32'h0);
      chk(rd, 32'h000000AB);
      apb(1'b0, abu_pkg::IDX_ADDRL, 32'h0);
      chk(rd, 32'h000000CD);
      apb(1'b0, 16'hE608, 32'h0);
      chk({rd[30:0], err}, 32'h00000001);
      $display("test regs done");
   endtask
   task automatic t_latch;
      apb(1'b1, abu_pkg::IDX_CTRL, 32'h00000002);
      cpu(16'hABCC, 1'b1, 1'b0);
      chk(breakpoint_pin, 1'b0);
      cpu(16'hAACD, 1'b1, 1'b0);
      chk(breakpoint_pin, 1'b0);
      cpu(16'hABCD, 1'b1, 1'b0);
      chk(breakpoint_pin, 1'b1);
      repeat (20) @(posedge pclk);
      chk(breakpoint_pin, 1'b1);
      apb(1'b0, abu_pkg::IDX_CTRL, 32'h0);
      chk(rd, 32'h0000000A);
      apb(1'b1, abu_pkg::IDX_CTRL, 32'h00000002);
      chk(breakpoint_pin, 1'b1);
      apb(1'b1, abu_pkg::IDX_CTRL, 32'h0000000A);
      chk(breakpoint_pin, 1'b0);
      $display("test latch done");
   endtask
   task automatic t_irq;
      apb(1'b0, abu_pkg::IDX_STAT, 32'h0);
      chk({rd[30:0], irq}, 32'h00000002);
      apb(1'b1, abu_pkg::IDX_MASK, 32'h00000001);
      chk(irq, 1'b1);
      apb(1'b0, abu_pkg::IDX_MASK, 32'h0);
      chk(rd, 32'h00000001);
      apb(1'b1, abu_pkg::IDX_STAT, 32'h00000001);
      chk(irq, 1'b0);
      $display("test irq done");
   endtask
   task automatic t_pulse;
      apb(1'b1, abu_pkg::IDX_CTRL, 32'h00000006);
      cpu(16'hABCD, 1'b0, 1'b1);
      chk(breakpoint_pin, 1'b1);
      chk(irq, 1'b1);
      // firmware leaves the flag alone in pulse mode
      repeat (10) @(posedge pclk);
      #1;
      chk(high_len, 8'h08);
      chk(breakpoint_pin, 1'b0);
      apb(1'b1, abu_pkg::IDX_CTRL, 32'h00000004);
      cpu(16'hABCD, 1'b1, 1'b1);
      chk(breakpoint_pin, 1'b0);
      $display("test pulse done");
   endtask
   // ----------------------------------------------------------------
   // sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_latch;
      t_irq;
      t_pulse;
      test_done;
   end
   initial begin
      repeat (4000) @(posedge pclk);
      failures++;
      test_done;
   end
endmodule
